// *** sim/testbench.sv ***
// self-checking bench of the haptic mode and trigger control
`default_nettype none
module testbench
	import haptic_mode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk;
	logic       rst;
	logic       regWr;
	logic       regRd;
	logic [7:0] regAddr;
	logic [7:0] regWdata;
	logic [7:0] regRdata, driveLevel;
	logic       pin, fault, playing, cancelPulse, driveFromPin, pinAnalog, pinAcCoupled, standby;
	int         bad_count = 0;
	int         n_compared = 0;
	int         cancels = 0;
	int         c;
	always #12.5 clk = ~clk;
	// cancel is a one-cycle pulse: count it rather than catch it
	always @(posedge clk) if (cancelPulse === 1'b1) cancels <= cancels + 1;
	trigger_source i_src
	(
		.clk             (clk),
		.pin             (pin),
		.fault           (fault)
	);
	// short routine keeps the run brief
	haptic_mode_trigger_control #(.RESET_CYC(4), .ROUT_CYC(8)) i_dut
	(
		.clk             (clk),
		.rst             (rst),
		.regWr           (regWr),
		.regRd           (regRd),
		.regAddr         (regAddr),
		.regWdata        (regWdata),
		.regRdata        (regRdata),
		.triggerInputPin (pin),
		.actuatorFault   (fault),
		.playing         (playing),
		.cancelPulse     (cancelPulse),
		.driveFromPin    (driveFromPin),
		.pinAnalog       (pinAnalog),
		.pinAcCoupled    (pinAcCoupled),
		.driveLevel      (driveLevel),
		.standby         (standby)
	);
	// ****************************************
	// tasks
	// ****************************************
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// idle cycle after each access lets registered outputs settle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr = a;
		regWdata = d;
		regWr = 1'b1;
		tick(1);
		regWr = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
		regAddr = a;
		regRd = 1'b1;
		tick(1);
		regRd = 1'b0;
		chk(regRdata & m, exp);
		tick(1);
	endtask
	task automatic waitIdle();
		for (int i = 0; i < 40 && playing !== 1'b0; i++) tick(1);
		if (playing !== 1'b0)
		begin
			bad_count++;
			close_out();
		end
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		tick(6);
		rst = 1'b0;
		tick(1);
		rd(MODE_ADDR, 8'h40);
		chk(8'(standby), 8'h01);
		rd(8'h7F, 8'h00);
		wr(MODE_ADDR, 8'h38);
		rd(MODE_ADDR, 8'h00);
		chk(8'(standby), 8'h00);
		$display("end defaults");
		i_src.setPin(1'b1);
		tick(2);
		chk(8'(playing), 8'h00);
		i_src.setPin(1'b0);
		wr(GO_ADDR, 8'h01);
		chk(8'(playing), 8'h01);
		wr(GO_ADDR, 8'h00);
		$display("end internal");
		wr(MODE_ADDR, 8'h01);
		c = cancels;
		i_src.setPin(1'b1);
		i_src.setPin(1'b0);
		tick(2);
		chk(8'(playing), 8'h01);
		i_src.setPin(1'b1);
		i_src.setPin(1'b0);
		tick(2);
		chk(8'(playing), 8'h00);
		chk(8'(cancels - c), 8'h01);
		$display("end edge");
		wr(MODE_ADDR, 8'h02);
		i_src.setPin(1'b1);
		tick(2);
		chk(8'(playing), 8'h01);
		c = cancels;
		wr(GO_ADDR, 8'h00);
		i_src.setPin(1'b0);
		tick(2);
		chk(8'(cancels - c), 8'h01);
		i_src.setPin(1'b1);
		i_src.setPin(1'b0);
		tick(2);
		chk(8'(cancels - c), 8'h02);
		chk(8'(playing), 8'h00);
		$display("end level");
		wr(CTRL_ADDR, 8'h22);
		wr(MODE_ADDR, 8'h03);
		chk(8'(driveFromPin), 8'h01);
		chk(8'(pinAnalog), 8'h01);
		wr(MODE_ADDR, 8'h04);
		chk(8'(driveFromPin), 8'h01);
		chk(8'(pinAcCoupled), 8'h01);
		wr(RTP_ADDR, 8'h85);
		wr(MODE_ADDR, 8'h05);
		chk(driveLevel, 8'h85);
		wr(CTRL_ADDR, 8'h08);
		chk(driveLevel, 8'h05);
		wr(MODE_ADDR, 8'h45);
		chk(driveLevel, 8'h00);
		$display("end drive");
		i_src.setFault(1'b1);
		wr(MODE_ADDR, 8'h06);
		wr(GO_ADDR, 8'h01);
		chk(8'(playing), 8'h01);
		waitIdle();
		rd(GO_ADDR, 8'h00, 8'h01);
		rd(STATUS_ADDR, 8'h08, 8'h08);
		rd(STATUS_ADDR, 8'h00, 8'h08);
		i_src.setFault(1'b0);
		wr(MODE_ADDR, 8'h07);
		wr(GO_ADDR, 8'h01);
		waitIdle();
		rd(GO_ADDR, 8'h00, 8'h01);
		rd(STATUS_ADDR, 8'h00, 8'h08);
		$display("end routines");
		wr(RTP_ADDR, 8'h33);
		wr(MODE_ADDR, 8'h00);
		wr(GO_ADDR, 8'h01);
		c = cancels;
		wr(MODE_ADDR, 8'h80);
		chk(8'(playing), 8'h00);
		rd(MODE_ADDR, 8'h80, 8'h80);
		tick(6);
		rd(MODE_ADDR, 8'h40);
		rd(RTP_ADDR, 8'h00);
		rd(CTRL_ADDR, 8'h00);
		rd(GO_ADDR, 8'h00);
		chk(8'(cancels - c), 8'h01);
		chk(8'(standby), 8'h01);
		$display("end soft reset");
		close_out();
	end
endmodule
`default_nettype wire

// *** sim/trigger_source.sv ***
// trigger pin and actuator fault source facing the block
`default_nettype none
module trigger_source
(
	input  wire logic clk,
	output var  logic pin,
	output var  logic fault
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		pin = 1'b0;
		fault = 1'b0;
	end
	// levels move just after an edge so the block never samples mid-change
	task automatic setPin(input logic v);
		@(posedge clk);
		#1;
		pin = v;
	endtask
	task automatic setFault(input logic v);
		@(posedge clk);
		#1;
		fault = v;
	endtask
endmodule
`default_nettype wire

// *** src/haptic_mode_pkg.sv ***
// constants of the haptic mode and trigger control block
`default_nettype none
package haptic_mode_pkg;
	localparam logic [7:0] STATUS_ADDR       = 8'h00;
	localparam logic [7:0] MODE_ADDR         = 8'h01;
	localparam logic [7:0] RTP_ADDR          = 8'h02;
	localparam logic [7:0] GO_ADDR           = 8'h0C;
	localparam logic [7:0] CTRL_ADDR         = 8'h1D;
	localparam int         RESET_BIT         = 7;
	localparam int         STANDBY_BIT       = 6;
	localparam int         OUTCOME_BIT       = 3;
	localparam int         GO_BIT            = 0;
	localparam int         FORMAT_BIT        = 3;
	localparam int         ACCOUPLE_BIT      = 5;
	localparam int         ANALOG_BIT        = 1;
	localparam logic       STANDBY_RESET     = 1'b1;
	localparam logic [2:0] MODE_RESET        = 3'h0;
	localparam logic [7:0] RTP_RESET         = 8'h00;
	localparam int         RESET_SPAN_CYC    = 4;
	localparam int         ROUTINE_CYC       = 64;
	typedef enum logic [2:0] {
		M_INTERNAL, M_EDGE, M_LEVEL, M_PWM, M_AUDIO, M_RTP, M_DIAG, M_CAL
	} op_mode_t;
endpackage
`default_nettype wire

// *** src/haptic_mode_trigger_control.sv ***
// mode register, go bit and trigger logic of the haptic driver
`default_nettype none
module haptic_mode_trigger_control
	import haptic_mode_pkg::*;
#(
	parameter int RESET_CYC = RESET_SPAN_CYC,
	parameter int ROUT_CYC  = ROUTINE_CYC
)(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       regWr,
	input  wire logic       regRd,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	output var  logic [7:0] regRdata,
	input  wire logic       triggerInputPin,
	input  wire logic       actuatorFault,
	output var  logic       playing,
	output var  logic       cancelPulse,
	output var  logic       driveFromPin,
	output var  logic       pinAnalog,
	output var  logic       pinAcCoupled,
	output var  logic [7:0] driveLevel,
	output var  logic       standby
);
	localparam int RW = $clog2(RESET_CYC + 1);
	// a zero span would leave the reset bit stuck high
	if (RESET_CYC < 1)
	begin : g_bad_reset_span
		$error("RESET_CYC must be positive");
	end
	// ****************************************
	// register state
	// ****************************************
	logic          softReset_r, softReset_nxt;
	logic [RW-1:0] rstCnt_r, rstCnt_nxt;
	logic          standby_r, standby_nxt;
	op_mode_t      mode_r, mode_nxt;
	logic [7:0]    rtp_r, rtp_nxt;
	logic          go_r, go_nxt;
	logic          outcome_r, outcome_nxt;
	logic          fmt_r, fmt_nxt;
	logic          acc_r, acc_nxt;
	logic          ana_r, ana_nxt;
	logic          trig_r;
	logic          cancel_nxt;
	logic [7:0]    rdata_nxt;
	logic [7:0]    drive_nxt;
	logic          routineMode;
	logic          rise, fall;
	routine_if     rt();
	routine_timer #(.CYCLES(ROUT_CYC)) u_timer (
		.clk     (clk),
		.rst     (rst),
		.abort   (softReset_r | ~go_r),
		.faultIn (actuatorFault),
		.rt      (rt)
	);
	assign rise = triggerInputPin & ~trig_r;
	assign fall = ~triggerInputPin & trig_r;
	assign routineMode = (mode_r == M_DIAG) || (mode_r == M_CAL);
	assign rt.start = go_r & routineMode & ~rt.busy & ~rt.done;
	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		softReset_nxt = softReset_r;
		rstCnt_nxt = rstCnt_r;
		standby_nxt = standby_r;
		mode_nxt = mode_r;
		rtp_nxt = rtp_r;
		go_nxt = go_r;
		outcome_nxt = outcome_r;
		fmt_nxt = fmt_r;
		acc_nxt = acc_r;
		ana_nxt = ana_r;
		cancel_nxt = 1'b0;
		if (softReset_r)
		begin
			// everything held at default while the reset runs
			standby_nxt = STANDBY_RESET;
			mode_nxt = op_mode_t'(MODE_RESET);
			rtp_nxt = RTP_RESET;
			go_nxt = 1'b0;
			outcome_nxt = 1'b0;
			fmt_nxt = 1'b0;
			acc_nxt = 1'b0;
			ana_nxt = 1'b0;
			rstCnt_nxt = rstCnt_r - 1'b1;
			if (rstCnt_r == RW'(1))
				softReset_nxt = 1'b0;
		end
		else
		begin
			if (regRd && regAddr == STATUS_ADDR)
				outcome_nxt = 1'b0;
			if (regWr)
			begin
				case (regAddr)
					MODE_ADDR:
					begin
						standby_nxt = regWdata[STANDBY_BIT];
						mode_nxt = op_mode_t'(regWdata[2:0]);
					end
					RTP_ADDR: rtp_nxt = regWdata;
					GO_ADDR:
					begin
						go_nxt = regWdata[GO_BIT];
						cancel_nxt = go_r & ~regWdata[GO_BIT];
					end
					CTRL_ADDR:
					begin
						fmt_nxt = regWdata[FORMAT_BIT];
						acc_nxt = regWdata[ACCOUPLE_BIT];
						ana_nxt = regWdata[ANALOG_BIT];
					end
					default: ;
				endcase
			end
			case (mode_r)
				M_EDGE:
				begin
					if (rise && go_r)
					begin
						go_nxt = 1'b0;
						cancel_nxt = 1'b1;
					end
					else if (rise)
						go_nxt = 1'b1;
				end
				M_LEVEL:
				begin
					if (rise && !go_r)
						go_nxt = 1'b1;
					else if (fall && go_r)
					begin
						go_nxt = 1'b0;
						cancel_nxt = 1'b1;
					end
					// matching state: nothing changes
				end
				M_DIAG, M_CAL:
				begin
					if (rt.done)
					begin
						go_nxt = 1'b0;
						outcome_nxt = rt.fail;
					end
				end
				default: ;
			endcase
			// reset request beats trigger edges and routine ends in the same cycle
			// defaults load at once so no output shows the written bits
			if (regWr && regAddr == MODE_ADDR && regWdata[RESET_BIT])
			begin
				softReset_nxt = 1'b1;
				rstCnt_nxt = RW'(RESET_CYC);
				standby_nxt = STANDBY_RESET;
				mode_nxt = op_mode_t'(MODE_RESET);
				rtp_nxt = RTP_RESET;
				go_nxt = 1'b0;
				outcome_nxt = 1'b0;
				fmt_nxt = 1'b0;
				acc_nxt = 1'b0;
				ana_nxt = 1'b0;
				cancel_nxt = go_r;
			end
		end
	end
	always_comb
	begin
		rdata_nxt = 8'h00;
		case (regAddr)
			STATUS_ADDR: rdata_nxt[OUTCOME_BIT] = outcome_r;
			MODE_ADDR:   rdata_nxt = {softReset_r, standby_r, 3'h0, mode_r};
			RTP_ADDR:    rdata_nxt = rtp_r;
			GO_ADDR:     rdata_nxt[GO_BIT] = go_r;
			CTRL_ADDR:   rdata_nxt = {2'h0, acc_r, 1'b0, fmt_r, 1'b0, ana_r, 1'b0};
			default:     rdata_nxt = 8'h00;
		endcase
		// unsigned values are shifted to offset-binary midscale
		drive_nxt = fmt_r ? {~rtp_r[7], rtp_r[6:0]} : rtp_r;
		drive_nxt = (mode_r == M_RTP && !standby_r) ? drive_nxt : 8'h00;
	end
	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			softReset_r <= 1'b0;
			rstCnt_r <= '0;
			standby_r <= STANDBY_RESET;
			mode_r <= op_mode_t'(MODE_RESET);
			rtp_r <= RTP_RESET;
			go_r <= 1'b0;
			outcome_r <= 1'b0;
			fmt_r <= 1'b0;
			acc_r <= 1'b0;
			ana_r <= 1'b0;
			trig_r <= 1'b0;
			regRdata <= 8'h00;
			playing <= 1'b0;
			cancelPulse <= 1'b0;
			driveFromPin <= 1'b0;
			pinAnalog <= 1'b0;
			pinAcCoupled <= 1'b0;
			driveLevel <= 8'h00;
			standby <= 1'b1;
		end
		else
		begin
			softReset_r <= softReset_nxt;
			rstCnt_r <= rstCnt_nxt;
			standby_r <= standby_nxt;
			mode_r <= mode_nxt;
			rtp_r <= rtp_nxt;
			go_r <= go_nxt;
			outcome_r <= outcome_nxt;
			fmt_r <= fmt_nxt;
			acc_r <= acc_nxt;
			ana_r <= ana_nxt;
			trig_r <= triggerInputPin;
			regRdata <= rdata_nxt;
			playing <= go_nxt & ~standby_nxt & ~softReset_nxt;
			cancelPulse <= cancel_nxt;
			driveFromPin <= (mode_nxt == M_PWM || mode_nxt == M_AUDIO) && !standby_nxt;
			pinAnalog <= ana_nxt;
			pinAcCoupled <= acc_nxt;
			driveLevel <= drive_nxt;
			standby <= standby_nxt;
		end
	end
	// ****************************************
	// checks
	// ****************************************
	a_reset_selfclear: assert property (@(posedge clk) disable iff (rst)
		$rose(softReset_r) |-> ##[1:64] !softReset_r) else $error("soft reset did not clear");
	a_reset_defaults: assert property (@(posedge clk) disable iff (rst)
		$fell(softReset_r) |-> standby_r && mode_r == M_INTERNAL && rtp_r == 8'h00 && !go_r
		&& !outcome_r && !fmt_r && !acc_r && !ana_r)
		else $error("registers not at default after soft reset");
	a_edge_sets_go: assert property (@(posedge clk) disable iff (rst)
		mode_r == M_EDGE && rise && !go_r && !regWr && !softReset_r |=> go_r) else $error("edge did not set go");
	a_edge_cancels: assert property (@(posedge clk) disable iff (rst)
		mode_r == M_EDGE && rise && go_r && !softReset_r |=> !go_r && cancelPulse) else $error("second edge no cancel");
	a_level_fall: assert property (@(posedge clk) disable iff (rst)
		mode_r == M_LEVEL && fall && go_r && !softReset_r |=> !go_r) else $error("fall did not cancel");
	a_level_hold: assert property (@(posedge clk) disable iff (rst)
		mode_r == M_LEVEL && rise && go_r && !regWr && !softReset_r |=> go_r && !cancelPulse)
		else $error("matching edge changed go");
	a_internal_nostart: assert property (@(posedge clk) disable iff (rst)
		mode_r == M_INTERNAL && !go_r && !(regWr && regAddr == GO_ADDR) |=> !go_r) else $error("go set without host");
	a_routine_clears: assert property (@(posedge clk) disable iff (rst)
		routineMode && rt.done && !softReset_r && !(regWr && regAddr == MODE_ADDR && regWdata[RESET_BIT])
		|=> !go_r && outcome_r == $past(actuatorFault))
		else $error("routine end not handled");
	a_outcome_read: assert property (@(posedge clk) disable iff (rst)
		regRd && regAddr == STATUS_ADDR && !(routineMode && rt.done) |=> !outcome_r) else $error("outcome not cleared");
	a_mode_reserved: assert property (@(posedge clk) disable iff (rst)
		regRd && regAddr == MODE_ADDR |=> regRdata[5:3] == 3'h0) else $error("reserved bits nonzero");
	c_soft_reset: cover property (@(posedge clk) disable iff (rst) $fell(softReset_r));
	c_edge_cancel: cover property (@(posedge clk) disable iff (rst) mode_r == M_EDGE && cancelPulse);
	c_routine_done: cover property (@(posedge clk) disable iff (rst) mode_r == M_CAL && rt.done);
	c_rtp_drive: cover property (@(posedge clk) disable iff (rst) mode_r == M_RTP && driveLevel != 8'h00);
endmodule
`default_nettype wire

// *** src/routine_if.sv ***
// start/done handshake between control and the routine timer
`default_nettype none
interface routine_if;
	logic start;
	logic busy;
	logic done;
	logic fail;
	modport ctrl  (output start, input busy, input done, input fail);
	modport timer (input start, output busy, output done, output fail);
endinterface
`default_nettype wire

// *** src/routine_timer.sv ***
// timer modelling diagnostic and calibration routines
`default_nettype none
module routine_timer
	import haptic_mode_pkg::*;
#(
	parameter int CYCLES = ROUTINE_CYC
)(
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  abort,
	input  wire logic  faultIn,
	routine_if.timer   rt
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         done_r;
	logic         done_nxt;
	// a zero length would never raise done
	if (CYCLES < 1)
	begin : g_bad_cycles
		$error("routine_timer: CYCLES must be positive");
	end
	always_comb
	begin
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		if (abort)
			cnt_nxt = '0;
		else if (cnt_r != '0)
		begin
			cnt_nxt = cnt_r - 1'b1;
			done_nxt = (cnt_r == W'(1));
		end
		else if (rt.start)
			cnt_nxt = W'(CYCLES);
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_r <= '0;
			done_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end
	assign rt.busy = (cnt_r != '0);
	assign rt.done = done_r;
	assign rt.fail = faultIn;
endmodule
`default_nettype wire
